// File: core/uart_smt.sv
// uart receive/transmit core with status, modem, test and id registers
// assumes avalon-mm master on clk_i, modem and serial inputs synchronous
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
`include "uart_smt_consts.svh"

module uart_smt
  import uart_smt_pkg::*;
#(
  parameter int          DEPTH      = 16,   // receive queue depth
  parameter int          BIT_CYCLES = 1736, // clk cycles per serial bit
  parameter logic        IR_INSIDE  = 1'b1  // infrared function present
) (
  input  wire logic        clk_i,          // 200 mhz clock
  input  wire logic        sys_rst_i,      // sync reset, active high
  input  wire avmm_req_t   bus_req_i,      // avalon-mm request
  output logic [31:0]      readdata_o,     // avalon-mm read data
  output logic             waitrequest_o,  // avalon-mm wait
  input  wire logic        sin_i,          // serial receive line
  output logic             sout_o,         // serial transmit line
  input  wire modem_in_t   modem_i,        // active-low modem inputs
  output logic             crc_fault_o,    // to fast ir tx: bad crc
  output logic             chip_fault_o,   // to fast ir tx: bad chips
  output logic             baud_boost_o,   // to baud gen: toggle boost
  output logic [4:0]       prescale_o      // fractional prescale value
);

  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                    ack;
    logic [31:0]             rdata;
    logic [`TST_WIDTH-1:0]   test;
    logic [7:0]              scratch;
    logic [`PSC_WIDTH-1:0]   presc;
    logic [1:0]              cfg;
    logic                    oe;
    logic                    pe;
    logic                    fe;
    logic [3:0]              delta;
    logic [3:0]              modem_prev;
    rx_state_t               rx_st;
    logic [15:0]             rx_cnt;
    logic [2:0]              rx_bit;
    logic [7:0]              rx_sh;
    logic                    rx_perr;
    logic                    rx_prev;
    logic [AW:0]             wptr;
    logic [AW:0]             rptr;
    rx_entry_t [DEPTH-1:0]   mem;
    tx_state_t               tx_st;
    logic [15:0]             tx_cnt;
    logic [2:0]              tx_bit;
    logic [7:0]              tx_sh;
    logic                    tx_par;
    logic                    tx_line;
    logic [7:0]              thr;
    logic                    thr_full;
  } state_t;

  state_t q;
  state_t d;

  localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] BIT_HALF = 16'(BIT_CYCLES / 2);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // parity bit to send or expect for a data byte
  function automatic logic parity_of(input logic [7:0] data, input logic even);
    parity_of = even ? (^data) : ~(^data);
  endfunction

  // one-hot queue depth code
  function automatic logic [3:0] depth_code(input int depth);
    if (depth >= 128) begin
      depth_code = 4'b1000;
    end else if (depth >= 64) begin
      depth_code = 4'b0100;
    end else if (depth >= 32) begin
      depth_code = 4'b0010;
    end else begin
      depth_code = 4'b0001;
    end
  endfunction

  logic        req;
  logic        capture;
  logic        accept;
  logic        q_empty;
  logic        q_full;
  logic        rx_tick;
  logic        rx_done;
  logic        push;
  rx_entry_t   head;
  logic [7:0]  lsr_val;
  logic [7:0]  msr_val;
  logic [7:0]  cap_val;
  logic [3:0]  modem_chg;
  logic [31:0] rd_val;
  logic        wr_low;

  assign req      = bus_req_i.read | bus_req_i.write;
  assign capture  = req & ~q.ack;
  assign accept   = req & q.ack;
  assign wr_low   = accept & bus_req_i.write & bus_req_i.byteenable[0];
  assign q_empty  = (q.wptr == q.rptr);
  assign q_full   = (q.wptr[AW] != q.rptr[AW]) && (q.wptr[AW-1:0] == q.rptr[AW-1:0]);
  assign head     = q.mem[q.rptr[AW-1:0]];
  assign rx_tick  = (q.rx_cnt == 16'h0000);
  assign rx_done  = rx_tick & (q.rx_st == RX_STOP);
  assign push     = rx_done & ~q_full;

  assign lsr_val = {1'b0,
                    ~q.thr_full & (q.tx_st == TX_IDLE),
                    ~q.thr_full,
                    1'b0,
                    q.fe, q.pe, q.oe, ~q_empty};

  assign msr_val = {~modem_i, q.delta};

  assign cap_val = {3'b000, IR_INSIDE, depth_code(DEPTH)};

  assign modem_chg = {modem_i.ndcd ^ q.modem_prev[3],
                      modem_i.nri & ~q.modem_prev[2],
                      modem_i.ndsr ^ q.modem_prev[1],
                      modem_i.ncts ^ q.modem_prev[0]};

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = `RST_WORD;
    if (bus_req_i.address == `OFS_RX_DATA) begin
      rd_val = {22'h00_0000, head.fe, head.pe, head.data};
    end else if (bus_req_i.address == `OFS_LINE_STATUS) begin
      rd_val = {24'h00_0000, lsr_val};
    end else if (bus_req_i.address == `OFS_MODEM) begin
      rd_val = {24'h00_0000, msr_val};
    end else if (bus_req_i.address == `OFS_SCRATCH) begin
      rd_val = {24'h00_0000, q.scratch};
    end else if (bus_req_i.address == `OFS_PRESCALE) begin
      rd_val = {27'h000_0000, q.presc};
    end else if (bus_req_i.address == `OFS_LINE_CFG) begin
      rd_val = {30'h0000_0000, q.cfg};
    end else if (bus_req_i.address == `OFS_CAPABILITY) begin
      rd_val = {24'h00_0000, cap_val};
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;

    // bus: one wait cycle, read data captured then, effects at accept
    d.ack = capture;
    if (capture && bus_req_i.read) begin
      d.rdata = rd_val;
    end
    if (wr_low && bus_req_i.address == `OFS_TEST) begin
      d.test = bus_req_i.writedata[`TST_WIDTH-1:0];
    end
    if (wr_low && bus_req_i.address == `OFS_SCRATCH) begin
      d.scratch = bus_req_i.writedata[7:0];
    end
    if (wr_low && bus_req_i.address == `OFS_PRESCALE) begin
      d.presc = bus_req_i.writedata[`PSC_WIDTH-1:0];
    end
    if (wr_low && bus_req_i.address == `OFS_LINE_CFG) begin
      d.cfg = bus_req_i.writedata[1:0];
    end

    // clear only what the reader saw; new events set below
    if (accept && bus_req_i.read && bus_req_i.address == `OFS_LINE_STATUS) begin
      d.fe = q.fe & ~q.rdata[`LSR_FRAMING_ERR];
      d.pe = q.pe & ~q.rdata[`LSR_PARITY_ERR];
      d.oe = q.oe & ~q.rdata[`LSR_OVERRUN];
    end
    // clear seen change flags, later changes survive
    if (accept && bus_req_i.read && bus_req_i.address == `OFS_MODEM) begin
      d.delta = q.delta & ~q.rdata[3:0];
    end
    d.delta = d.delta | modem_chg;
    d.modem_prev = modem_i;

    if (accept && bus_req_i.read && bus_req_i.address == `OFS_RX_DATA && !q_empty) begin
      d.rptr = q.rptr + 1'b1;
    end

    // ---------------- receiver ----------------
    d.rx_prev = sin_i;
    if (!rx_tick) begin
      d.rx_cnt = q.rx_cnt - 1'b1;
    end
    case (q.rx_st)
      RX_IDLE: begin
        if (!sin_i && q.rx_prev) begin
          d.rx_st  = RX_START;
          d.rx_cnt = BIT_HALF;
        end
      end
      RX_RESYNC: begin
        // a zero here is taken as a new start bit
        if (!sin_i) begin
          d.rx_st  = RX_START;
          d.rx_cnt = BIT_HALF;
        end else begin
          d.rx_st = RX_IDLE;
        end
      end
      RX_START: begin
        if (rx_tick) begin
          d.rx_st   = sin_i ? RX_IDLE : RX_DATA;
          d.rx_cnt  = BIT_LAST;
          d.rx_bit  = 3'd0;
          d.rx_perr = 1'b0;
        end
      end
      RX_DATA: begin
        if (rx_tick) begin
          d.rx_sh  = {sin_i, q.rx_sh[7:1]};
          d.rx_bit = q.rx_bit + 1'b1;
          d.rx_cnt = BIT_LAST;
          if (q.rx_bit == 3'd7) begin
            d.rx_st = q.cfg[`CFG_PARITY_EN] ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (rx_tick) begin
          d.rx_perr = (sin_i != parity_of(q.rx_sh, q.cfg[`CFG_EVEN]));
          d.rx_cnt  = BIT_LAST;
          d.rx_st   = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rx_tick) begin
          // framing error leads to resync check
          d.rx_st = sin_i ? RX_IDLE : RX_RESYNC;
        end
      end
      default: d.rx_st = RX_IDLE;
    endcase

    if (push) begin
      d.mem[q.wptr[AW-1:0]] = '{fe: ~sin_i, pe: q.rx_perr, data: q.rx_sh};
      d.wptr = q.wptr + 1'b1;
      d.fe   = d.fe | ~sin_i;
      d.pe   = d.pe | q.rx_perr;
    end
    // overrun when queue full at completion
    if (rx_done && q_full) begin
      d.oe = 1'b1;
    end

    // ---------------- transmitter ----------------
    if (wr_low && bus_req_i.address == `OFS_TX_DATA && !q.thr_full) begin
      d.thr      = bus_req_i.writedata[7:0];
      d.thr_full = 1'b1;
    end
    if (q.tx_cnt != 16'h0000) begin
      d.tx_cnt = q.tx_cnt - 1'b1;
    end
    case (q.tx_st)
      TX_IDLE: begin
        if (q.thr_full) begin
          d.thr_full = 1'b0;
          d.tx_sh    = q.thr;
          d.tx_par   = parity_of(q.thr, q.cfg[`CFG_EVEN]);
          d.tx_line  = 1'b0;
          d.tx_cnt   = BIT_LAST;
          d.tx_st    = TX_START;
        end
      end
      TX_START: begin
        if (q.tx_cnt == 16'h0000) begin
          d.tx_line = q.tx_sh[0];
          d.tx_bit  = 3'd0;
          d.tx_cnt  = BIT_LAST;
          d.tx_st   = TX_DATA;
        end
      end
      TX_DATA: begin
        if (q.tx_cnt == 16'h0000) begin
          d.tx_cnt = BIT_LAST;
          d.tx_bit = q.tx_bit + 1'b1;
          d.tx_sh  = {1'b0, q.tx_sh[7:1]};
          if (q.tx_bit != 3'd7) begin
            d.tx_line = q.tx_sh[1];
          end else if (q.cfg[`CFG_PARITY_EN]) begin
            d.tx_line = q.tx_par ^ q.test[`TST_PARITY_FAULT];
            d.tx_st   = TX_PAR;
          end else begin
            d.tx_line = ~q.test[`TST_STOP_FAULT];
            d.tx_st   = TX_STOP;
          end
        end
      end
      TX_PAR: begin
        if (q.tx_cnt == 16'h0000) begin
          d.tx_line = ~q.test[`TST_STOP_FAULT];
          d.tx_cnt  = BIT_LAST;
          d.tx_st   = TX_STOP;
        end
      end
      TX_STOP: begin
        if (q.tx_cnt == 16'h0000) begin
          d.tx_line = 1'b1;
          d.tx_st   = TX_IDLE;
        end
      end
      default: d.tx_st = TX_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      q            <= '0;
      q.rdata      <= `RST_WORD;
      q.test       <= `RST_TEST;
      q.scratch    <= `RST_BYTE;
      q.presc      <= `RST_PSC;
      q.cfg        <= `RST_CFG;
      q.modem_prev <= `RST_MODEM_PREV;
      q.rx_st      <= RX_IDLE;
      q.rx_prev    <= 1'b1;
      q.tx_st      <= TX_IDLE;
      q.tx_line    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign readdata_o    = q.rdata;
  assign waitrequest_o = capture;
  assign sout_o        = q.tx_line;
  assign crc_fault_o   = q.test[`TST_CRC_FAULT];
  assign chip_fault_o  = q.test[`TST_CHIP_FAULT];
  assign baud_boost_o  = q.test[`TST_BAUD_BOOST];
  assign prescale_o    = q.presc;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  framing_flag_a: assert property (push && !sin_i |=> q.fe && q.mem[$past(q.wptr[AW-1:0])].fe)
    else $error("framing error not flagged");

  resync_start_a: assert property (rx_done && !sin_i ##1 !sin_i |=> q.rx_st == RX_START)
    else $error("no resync after framing error");

  lsr_clear_a: assert property (accept && bus_req_i.read && bus_req_i.address == `OFS_LINE_STATUS
      && q.rdata[`LSR_FRAMING_ERR] && !push |=> !q.fe)
    else $error("framing flag survived status read");

  parity_flag_a: assert property (push && q.rx_perr |=> q.pe)
    else $error("parity error not flagged");

  overrun_flag_a: assert property (rx_done && q_full |=> q.oe && $stable(q.wptr))
    else $error("overrun not flagged");

  data_ready_a: assert property (accept && bus_req_i.read && bus_req_i.address == `OFS_LINE_STATUS
      |-> readdata_o[`LSR_DATA_READY] == ($past(q.wptr) != $past(q.rptr)))
    else $error("data ready wrong");

  stop_fault_a: assert property (q.tx_st == TX_STOP && $past(q.tx_st) != TX_STOP
      |-> sout_o == ~q.test[`TST_STOP_FAULT])
    else $error("stop bit fault not applied");

  parity_fault_a: assert property (q.tx_st == TX_PAR
      |-> sout_o == (q.tx_par ^ q.test[`TST_PARITY_FAULT]))
    else $error("parity fault not applied");

  modem_level_a: assert property (accept && bus_req_i.read && bus_req_i.address == `OFS_MODEM
      |-> readdata_o[7:4] == ~$past(modem_i))
    else $error("modem levels not inverted");

  ring_rise_a: assert property (!q.modem_prev[2] && modem_i.nri |=> q.delta[2])
    else $error("ring rise not flagged");

  carrier_change_a: assert property (modem_i.ndcd != q.modem_prev[3] |=> q.delta[3])
    else $error("carrier change not flagged");

  capability_a: assert property (capture && bus_req_i.read && bus_req_i.address == `OFS_CAPABILITY
      |=> readdata_o[4:0] == {IR_INSIDE, depth_code(DEPTH)})
    else $error("capability value wrong");

endmodule

// File: core/uart_smt_consts.svh
// offsets, field positions, reset values for the uart status block
// assumes byte addresses on a 32-bit avalon-mm slave, one word each
`ifndef UART_SMT_CONSTS_SVH
`define UART_SMT_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_RX_DATA      8'h00
`define OFS_TX_DATA      8'h04
`define OFS_TEST         8'h14
`define OFS_MODEM        8'h18
`define OFS_SCRATCH      8'h1c
`define OFS_PRESCALE     8'h20
`define OFS_LINE_CFG     8'h24
`define OFS_LINE_STATUS  8'h28
`define OFS_CAPABILITY   8'h68

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LSR_DATA_READY   0
`define LSR_OVERRUN      1
`define LSR_PARITY_ERR   2
`define LSR_FRAMING_ERR  3
`define LSR_THR_EMPTY    5
`define LSR_TX_EMPTY     6
`define TST_CRC_FAULT    4
`define TST_CHIP_FAULT   3
`define TST_BAUD_BOOST   2
`define TST_STOP_FAULT   1
`define TST_PARITY_FAULT 0
`define TST_WIDTH        5
`define PSC_WIDTH        5
`define CFG_PARITY_EN    0
`define CFG_EVEN         1
`define CAP_IR_INSIDE    4
`define RXD_FE           9
`define RXD_PE           8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_BYTE         8'h00
`define RST_TEST         5'h00
`define RST_PSC          5'h00
`define RST_CFG          2'h0
`define RST_MODEM_PREV   4'hf
`define RST_WORD         32'h0000_0000

`endif

// File: core/uart_smt_pkg.sv
// types shared by the uart status block and its bench
// assumes the constants header for all numeric values
package uart_smt_pkg;

  // avalon-mm request bundle from the master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avmm_req_t;

  // active-low modem inputs, order matches status bits 7..4
  typedef struct packed {
    logic ndcd;
    logic nri;
    logic ndsr;
    logic ncts;
  } modem_in_t;

  // one receive queue entry with its queued error flags
  typedef struct packed {
    logic       fe;
    logic       pe;
    logic [7:0] data;
  } rx_entry_t;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_RESYNC
  } rx_state_t;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
  } tx_state_t;

endpackage

// File: test/modem_peer.sv
// model of the modem or data set on the serial line side of the uart
// assumes the bench calls its tasks; one serial bit lasts BIT_CYCLES clocks
`timescale 1ns/1ps

module modem_peer
  import uart_smt_pkg::*;
#(
  parameter int BIT_CYCLES = 8  // clocks per serial bit
) (
  input  wire logic  clk_i,    // bench clock
  input  wire logic  sout_i,   // line from the uart
  output logic       sin_o,    // line to the uart
  output modem_in_t  modem_o   // active-low modem levels
);
  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  initial begin
    sin_o   = 1'b1;
    modem_o = 4'hf;
  end

  task automatic set_modem(input modem_in_t v);
    @(posedge clk_i);
    modem_o <= v;
  endtask

  // start, 8 data lsb first, even parity, stop; faults on request
  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    logic [10:0] f;
    f = {~bad_stop, (^d) ^ bad_par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_i);
      sin_o <= f[i];
      repeat (BIT_CYCLES - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    sin_o <= 1'b1;
  endtask

  // samples one frame at bit centres: {stop, parity, data}
  task automatic get_frame(output logic [9:0] f);
    @(negedge sout_i);
    repeat (BIT_CYCLES / 2) @(posedge clk_i);
    for (int i = 0; i < 10; i++) begin
      repeat (BIT_CYCLES) @(posedge clk_i);
      f[i] = sout_i;
    end
  endtask
endmodule

// File: test/uart_smt_bench.sv
// self-checking bench for the uart status, modem, test and id registers
// assumes the modem_peer model on the serial and modem side
`timescale 1ns/1ps
`include "uart_smt_consts.svh"

module uart_smt_bench
  import uart_smt_pkg::*;
;
  localparam int BC = 8;
  logic        clk_i;
  logic        sys_rst_i;
  avmm_req_t   bus_req_i;
  logic [31:0] readdata_o;
  logic        waitrequest_o;
  logic        sin_i;
  logic        sout_o;
  modem_in_t   modem_i;
  logic        crc_fault_o;
  logic        chip_fault_o;
  logic        baud_boost_o;
  logic [4:0]  prescale_o;
  logic [31:0] rv;
  logic [9:0]  fr;
  int          error_cnt;
  int          samples_checked;

  uart_smt #(.BIT_CYCLES(BC)) u_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_req_i(bus_req_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .sin_i(sin_i),
    .sout_o(sout_o), .modem_i(modem_i), .crc_fault_o(crc_fault_o),
    .chip_fault_o(chip_fault_o), .baud_boost_o(baud_boost_o), .prescale_o(prescale_o)
  );

  modem_peer #(.BIT_CYCLES(BC)) u_peer (
    .clk_i(clk_i), .sout_i(sout_o), .sin_o(sin_i), .modem_o(modem_i)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one avalon-mm transfer, held until waitrequest is seen low
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] wd,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk_i);
    bus_req_i <= '{read: rd, write: ~rd, address: a, writedata: wd, byteenable: be};
    // hold until waitrequest is sampled low at a rising edge
    do begin
      @(posedge clk_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 100);
    if (n >= 100) error_cnt++;
    // read data stands at the same edge
    rv = readdata_o;
    bus_req_i.read  <= 1'b0;
    bus_req_i.write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b0, a, {16'h0000, d}, 4'hf);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    bus(1'b1, a, 32'h0000_0000, 4'hf);
    chk(rv, {16'h0000, exp});
  endtask

  task automatic rx(input logic [7:0] d, input logic bp, input logic bs);
    u_peer.send(d, bp, bs);
    repeat (2 * BC) @(posedge clk_i);
  endtask

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #100000;
    error_cnt++;
    test_done();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    sys_rst_i       = 1'b1;
    bus_req_i       = '0;
    error_cnt       = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd_chk(`OFS_SCRATCH, 16'h0000);         // scratch reset
    rd_chk(`OFS_PRESCALE, 16'h0000);        // prescale reset
    rd_chk(`OFS_MODEM, 16'h0000);           // no change at idle
    rd_chk(`OFS_CAPABILITY, 16'h0011);      // infrared and depth
    rd_chk(8'h30, 16'h0000);                // unmapped reads zero
    rd_chk(`OFS_LINE_STATUS, 16'h0060);     // nothing received
    $display("test reset done");
    wr(`OFS_SCRATCH, 16'h00a5);
    rd_chk(`OFS_SCRATCH, 16'h00a5);         // scratch holds
    bus(1'b0, `OFS_SCRATCH, 32'h0000_0077, 4'h0);
    rd_chk(`OFS_SCRATCH, 16'h00a5);         // disabled lane ignored
    wr(`OFS_PRESCALE, 16'h00ff);
    rd_chk(`OFS_PRESCALE, 16'h001f);        // five prescale bits kept
    chk(prescale_o, 32'h0000_001f);         // prescale value out
    $display("test registers done");
    wr(`OFS_TEST, 16'h001f);
    @(negedge clk_i);
    chk({crc_fault_o, chip_fault_o, baud_boost_o}, 3'b111); // fault levels
    rd_chk(`OFS_TEST, 16'h0000);            // write-only reads zero
    wr(`OFS_LINE_CFG, 16'h0003);
    wr(`OFS_TEST, 16'h0003);
    fork
      u_peer.get_frame(fr);
      wr(`OFS_TX_DATA, 16'h0001);
    join
    chk(fr, 10'h001);                       // zero stop, wrong parity
    wr(`OFS_TEST, 16'h0000);
    @(negedge clk_i);
    chk({crc_fault_o, chip_fault_o, baud_boost_o}, 3'b000); // faults off
    fork
      u_peer.get_frame(fr);
      wr(`OFS_TX_DATA, 16'h0081);
    join
    chk(fr, 10'h281);                       // clean frame
    $display("test injection done");
    u_peer.set_modem(4'h0);
    repeat (3) @(posedge clk_i);
    rd_chk(`OFS_MODEM, 16'h00fb);           // all low
    rd_chk(`OFS_MODEM, 16'h00f0);           // flags cleared by read
    u_peer.set_modem(4'b0100);
    repeat (3) @(posedge clk_i);
    rd_chk(`OFS_MODEM, 16'h00b4);           // ring trailing edge
    u_peer.set_modem(4'hf);
    repeat (3) @(posedge clk_i);
    rd_chk(`OFS_MODEM, 16'h000b);           // rising of the others
    rd_chk(`OFS_MODEM, 16'h0000);           // cleared again
    $display("test modem done");
    rx(8'h5a, 1'b0, 1'b0);
    rd_chk(`OFS_LINE_STATUS, 16'h0061);     // data waiting
    rd_chk(`OFS_RX_DATA, 16'h005a);         // clean character
    rd_chk(`OFS_LINE_STATUS, 16'h0060);     // cleared when empty
    rx(8'h3c, 1'b0, 1'b1);
    rd_chk(`OFS_LINE_STATUS, 16'h0069);     // framing reported
    rd_chk(`OFS_LINE_STATUS, 16'h0061);     // cleared by read
    rd_chk(`OFS_RX_DATA, 16'h023c);         // flag queued with data
    rx(8'hc3, 1'b1, 1'b0);
    rd_chk(`OFS_LINE_STATUS, 16'h0065);     // parity reported
    rd_chk(`OFS_RX_DATA, 16'h01c3);         // flag queued with data
    $display("test receive errors done");
    for (int i = 0; i < 17; i++) rx(i[7:0], 1'b0, 1'b0);
    rd_chk(`OFS_LINE_STATUS, 16'h0063);     // overrun on full queue
    for (int i = 0; i < 16; i++) rd_chk(`OFS_RX_DATA, i[15:0]); // queue order
    rd_chk(`OFS_LINE_STATUS, 16'h0060);     // overrun cleared, empty
    $display("test overrun done");
    test_done();
  end
endmodule
